// >>> bench/gsw_board.sv
// Purpose: board model for the pin, strap and wake block
// Assumes: pin 2 pulled up, other pins pulled down
// Notes: EEPROM word is the command then its inverse
`timescale 1ns/1ps
module gsw_board
    import gsw_pkg::*;
(
    input wire logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_out,
    input wire logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_oe,
    input wire logic [7:0] strap_en,
    input wire logic [7:0] strap_val,
    output logic [gsw_pkg::GSW_PIN_COUNT-1:0] pin_level,
    input wire logic eeprom_select,
    input wire logic eeprom_clock_out,
    input wire logic eeprom_serial_out,
    output logic eeprom_serial_in
);
    import gsw_pkg::*;
    localparam logic [7:0] PULL = 8'h04;
    logic [7:0] cmd_reg;
    logic dout;
    logic [15:0] word;
    int bit_cnt;
    // ----------------------------------------
    // Pins and serial memory
    // ----------------------------------------
    // wire resolution
    assign pin_level = (gpio_oe & gpio_out) | (~gpio_oe & strap_en & strap_val)
        | (~gpio_oe & ~strap_en & PULL);
    // released line floats to its pull-up
    assign eeprom_serial_in = eeprom_select ? dout : 1'b1;
    assign word = {cmd_reg, ~cmd_reg};
    initial bit_cnt = 0;
    always @(posedge eeprom_clock_out or negedge eeprom_select)
        if (!eeprom_select)
            bit_cnt <= 0;
        else
        begin
            if (bit_cnt < 8)
                cmd_reg <= {cmd_reg[6:0], eeprom_serial_out};
            bit_cnt <= bit_cnt + 1;
        end
    always @(negedge eeprom_clock_out)
        if (eeprom_select && bit_cnt >= 8 && bit_cnt < 24)
            dout <= word[23 - bit_cnt];
endmodule : gsw_board

// >>> bench/gsw_top_tb.sv
// Purpose: self-checking bench for the pin, strap and wake block
// Assumes: inputs driven on the falling clock edge
// Notes: strap values and pin data are random
`timescale 1ns/1ps
module gsw_top_tb;
    import gsw_pkg::*;
    localparam logic [7:0] PULL = 8'h04;
    logic clock, rst_b, system_reset_in_n, gpio_oe_write, ring_indicate_ch0, link_in_l2;
    logic ee_start, eeprom_org_strap, straps_valid, wake_n, ee_busy, ee_data_valid;
    logic eeprom_select, eeprom_clock_out, eeprom_serial_out, eeprom_serial_in;
    logic [7:0] gpio_in, gpio_out, gpio_oe, gpio_out_value, gpio_oe_value, gpio_read;
    logic [7:0] ee_command, strap_en, strap_val, p_lat;
    logic [1:0] rx_termination_adjust, tx_termination_adjust;
    logic [2:0] driver_equalization;
    logic [15:0] ee_data;
    logic [15:0] exp_q[$];
    int bad_count, checks;
    gsw_top #(.EE_BITS(16)) uut (.clock(clock), .rst_b(rst_b),
        .system_reset_in_n(system_reset_in_n), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_out_value(gpio_out_value), .gpio_oe_value(gpio_oe_value),
        .gpio_oe_write(gpio_oe_write), .gpio_read(gpio_read),
        .eeprom_org_strap(eeprom_org_strap), .rx_termination_adjust(rx_termination_adjust),
        .tx_termination_adjust(tx_termination_adjust),
        .driver_equalization(driver_equalization), .straps_valid(straps_valid),
        .ring_indicate_ch0(ring_indicate_ch0), .link_in_l2(link_in_l2), .wake_n(wake_n),
        .ee_start(ee_start), .ee_command(ee_command), .ee_busy(ee_busy), .ee_data(ee_data),
        .ee_data_valid(ee_data_valid), .eeprom_select(eeprom_select),
        .eeprom_clock_out(eeprom_clock_out), .eeprom_serial_out(eeprom_serial_out),
        .eeprom_serial_in(eeprom_serial_in));
    gsw_board board (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .strap_en(strap_en),
        .strap_val(strap_val), .pin_level(gpio_in), .eeprom_select(eeprom_select),
        .eeprom_clock_out(eeprom_clock_out), .eeprom_serial_out(eeprom_serial_out),
        .eeprom_serial_in(eeprom_serial_in));
    initial
    begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [7:0] pins(input logic [7:0] oe, input logic [7:0] out);
        return (oe & out) | (~oe & strap_en & strap_val) | (~oe & ~strap_en & PULL);
    endfunction : pins
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic strap(input logic [7:0] en, input logic [7:0] val);
        @(negedge clock);
        system_reset_in_n = 0;
        strap_en = en;
        strap_val = val;
        repeat (3) @(negedge clock);
        // Start only after straps_valid has dropped, so the refusal is tested
        ee_start = 1;
        repeat (2) @(negedge clock);
        check("oe_in_reset", gpio_oe, 16'h0000);
        check("busy_in_reset", ee_busy, 16'h0000);
        check("valid_in_reset", straps_valid, 16'h0000);
        ee_start = 0;
        system_reset_in_n = 1;
        p_lat = pins(8'h00, 8'h00);
        for (int i = 0; i < 10 && straps_valid !== 1'b1; i++) @(negedge clock);
        check("valid", straps_valid, 16'h0001);
        check("org", eeprom_org_strap, p_lat[7]);
        check("rx_adj", rx_termination_adjust, p_lat[6:5]);
        check("tx_adj", tx_termination_adjust, p_lat[4:3]);
        check("deq", driver_equalization, p_lat[2:0]);
        strap_val = ~val;
        repeat (5) @(negedge clock);
        check("hold", {eeprom_org_strap, rx_termination_adjust, tx_termination_adjust,
            driver_equalization}, p_lat);
        $display("test strap done");
    endtask : strap
    task automatic ee_read(input logic [7:0] cmd);
        int n;
        @(negedge clock);
        ee_command = cmd;
        ee_start = 1;
        exp_q.push_back({cmd, ~cmd});
        @(negedge clock);
        ee_start = 0;
        check("select", eeprom_select, 16'h0001);
        n = 0;
        while (ee_data_valid !== 1'b1 && n < 400)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check("ee_valid", ee_data_valid, 16'h0001);
        check("ee_data", ee_data, exp_q.pop_front());
        $display("test eeprom read done");
    endtask : ee_read
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        rst_b = 0;
        system_reset_in_n = 0;
        {gpio_oe_write, gpio_oe_value, gpio_out_value, ee_start, ee_command} = '0;
        {ring_indicate_ch0, link_in_l2, strap_en, strap_val} = '0;
        void'($urandom(32'h98e8));
        repeat (12) @(negedge clock);
        rst_b = 1;
        strap(8'h00, 8'h00);
        repeat (4) strap(8'($urandom), 8'($urandom));
        repeat (4)
        begin
            @(negedge clock);
            gpio_oe_value = 8'($urandom);
            gpio_out_value = 8'($urandom);
            gpio_oe_write = 1;
            @(negedge clock);
            gpio_oe_write = 0;
            check("oe", gpio_oe, gpio_oe_value);
            check("out", gpio_out, gpio_out_value);
            repeat (5) @(negedge clock);
            check("read", gpio_read, pins(gpio_oe_value, gpio_out_value));
            check("hold", {eeprom_org_strap, rx_termination_adjust, tx_termination_adjust,
                driver_equalization}, p_lat);
        end
        $display("test gpio done");
        for (int k = 0; k < 5; k++)
        begin
            {link_in_l2, ring_indicate_ch0} = 2'(k % 4);
            repeat (5) @(negedge clock);
            check("wake", wake_n, !(k == 3));
        end
        $display("test wake done");
        ee_read(8'($urandom));
        ee_read(8'($urandom));
        complete_run();
    end
    initial
    begin
        #200000;
        bad_count++;
        $display("[FAIL] watchdog expected done seen hang");
        complete_run();
    end
endmodule : gsw_top_tb

// >>> src/gsw_pkg.sv
// Purpose: constants for the general-purpose pin, strap and wake block
// Assumes: one 100 MHz clock, asynchronous active-low reset
// Notes: strap defaults apply while reset is held
package gsw_pkg;
    localparam int GSW_PIN_COUNT = 8;
    localparam int GSW_ORG_BIT = 7;
    localparam int GSW_RXADJ_HI = 6;
    localparam int GSW_RXADJ_LO = 5;
    localparam int GSW_TXADJ_HI = 4;
    localparam int GSW_TXADJ_LO = 3;
    localparam int GSW_DEQ_HI = 2;
    localparam int GSW_DEQ_LO = 0;
    localparam logic GSW_ORG_RESET = 1'h0;
    localparam logic [1:0] GSW_RXADJ_RESET = 2'h0;
    localparam logic [1:0] GSW_TXADJ_RESET = 2'h0;
    localparam logic [2:0] GSW_DEQ_RESET = 3'h4;
    localparam logic [7:0] GSW_OE_RESET = 8'h00;
    // Serial clock divider: half period in core cycles
    localparam int GSW_EE_HALF_NS = 40;
    localparam int GSW_CLK_NS = 10;
    localparam int GSW_EE_HALF_CYC = (GSW_EE_HALF_NS + GSW_CLK_NS - 1) / GSW_CLK_NS;
    typedef enum logic [1:0]
    {
        GSW_EE_IDLE = 2'b00,
        GSW_EE_SHIFT = 2'b01,
        GSW_EE_DONE = 2'b11
    } gsw_ee_state_t;
endpackage : gsw_pkg

// >>> src/gsw_sync.sv
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs asynchronous to clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module gsw_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    initial
    begin
        if (WIDTH < 1)
            $error("gsw_sync width must be positive");
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= INIT;
            sync_out <= INIT;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : gsw_sync

// >>> src/gsw_top.sv
// Purpose: general-purpose pins, reset-time straps, wake output, EEPROM reader
// Assumes: system_reset_in_n is an asynchronous pin; rst_b is the core reset
// Notes: straps are latched on the third clock edge after system reset release (two synchroniser stages, then capture)
`timescale 1ns/1ps
//
// Function
// - Eight general-purpose pins; output-enable control makes each input-only or bidirectional.
// - Pin 7 sampled at initialization; high selects 16-bit EEPROM organization.
// - Pins 6 and 5 sampled as receive termination adjust, default 00.
// - Pins 4 and 3 sampled as transmit termination adjust, default 00.
// - Pins 2 to 0 sampled as equalization bits 3 to 1, default 100.
// - Wake output goes low on channel 0 ring indication in L2.
// - Device drives EEPROM select, clock, data out; EEPROM answers on serial input.
module gsw_top
    import gsw_pkg::*;
#(
    parameter int EE_BITS = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic system_reset_in_n,
    input wire logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_in,
    output logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_out,
    output logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_oe,
    input wire logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_out_value,
    input wire logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_oe_value,
    input wire logic gpio_oe_write,
    output logic [gsw_pkg::GSW_PIN_COUNT-1:0] gpio_read,
    output logic eeprom_org_strap,
    output logic [1:0] rx_termination_adjust,
    output logic [1:0] tx_termination_adjust,
    output logic [2:0] driver_equalization,
    output logic straps_valid,
    input wire logic ring_indicate_ch0,
    input wire logic link_in_l2,
    output logic wake_n,
    input wire logic ee_start,
    input wire logic [7:0] ee_command,
    output logic ee_busy,
    output logic [EE_BITS-1:0] ee_data,
    output logic ee_data_valid,
    output logic eeprom_select,
    output logic eeprom_clock_out,
    output logic eeprom_serial_out,
    input wire logic eeprom_serial_in
);
    import gsw_pkg::*;

    initial
    begin
        if (EE_BITS < 2 || EE_BITS > 32)
            $error("gsw_top EE_BITS out of range");
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [GSW_PIN_COUNT-1:0] pin_sync;
    logic [2:0] misc_sync;
    logic sysrst_sync;
    logic ring_sync;
    logic ee_in_sync;

    gsw_sync #(.WIDTH(GSW_PIN_COUNT), .INIT('0)) u_pin_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(gpio_in),
        .sync_out(pin_sync)
    );

    gsw_sync #(.WIDTH(3), .INIT(3'h0)) u_misc_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in({system_reset_in_n, ring_indicate_ch0, eeprom_serial_in}),
        .sync_out(misc_sync)
    );

    assign sysrst_sync = misc_sync[2];
    assign ring_sync = misc_sync[1];
    assign ee_in_sync = misc_sync[0];

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    logic sysrst_d_reg;
    logic strap_take;
    assign strap_take = sysrst_sync && !sysrst_d_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            sysrst_d_reg <= 1'b0;
        else
            sysrst_d_reg <= sysrst_sync;
    end

    // capture on release
    // Pins forced to input while system reset held, so straps are never self-driven
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            eeprom_org_strap <= GSW_ORG_RESET;
            rx_termination_adjust <= GSW_RXADJ_RESET;
            tx_termination_adjust <= GSW_TXADJ_RESET;
            driver_equalization <= GSW_DEQ_RESET;
            straps_valid <= 1'b0;
        end
        else if (!sysrst_sync)
        begin
            straps_valid <= 1'b0;
        end
        else if (strap_take)
        begin
            eeprom_org_strap <= pin_sync[GSW_ORG_BIT];
            rx_termination_adjust <= pin_sync[GSW_RXADJ_HI:GSW_RXADJ_LO];
            tx_termination_adjust <= pin_sync[GSW_TXADJ_HI:GSW_TXADJ_LO];
            driver_equalization <= pin_sync[GSW_DEQ_HI:GSW_DEQ_LO];
            straps_valid <= 1'b1;
        end
    end

    // ----------------------------------------
    // General-purpose pins
    // ----------------------------------------
    logic [GSW_PIN_COUNT-1:0] oe_reg;
    logic [GSW_PIN_COUNT-1:0] out_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oe_reg <= GSW_OE_RESET;
            out_reg <= '0;
        end
        else if (!sysrst_sync)
            oe_reg <= GSW_OE_RESET;
        else if (gpio_oe_write)
        begin
            oe_reg <= gpio_oe_value;
            out_reg <= gpio_out_value;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < GSW_PIN_COUNT; gi++)
        begin : g_pin
            assign gpio_oe[gi] = oe_reg[gi] && straps_valid;
            assign gpio_out[gi] = out_reg[gi];
        end
    endgenerate
    assign gpio_read = pin_sync;

    // ----------------------------------------
    // Wake output
    // ----------------------------------------
    logic wake_reg;
    // ring in L2 pulls wake low; held while both stand
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            wake_reg <= 1'b0;
        else
            wake_reg <= ring_sync && link_in_l2;
    end
    assign wake_n = !wake_reg;

    // ----------------------------------------
    // EEPROM serial reader
    // ----------------------------------------
    localparam int EE_TOTAL = 8 + EE_BITS;
    gsw_ee_state_t ee_state_reg;
    logic [5:0] ee_bit_reg;
    logic [7:0] ee_div_reg;
    logic [7:0] ee_cmd_reg;
    logic [EE_BITS-1:0] ee_shift_reg;
    logic ee_clk_reg;
    logic ee_tick;
    logic ee_rise;
    logic ee_last;
    assign ee_tick = (ee_div_reg == 8'(GSW_EE_HALF_CYC - 1));
    assign ee_rise = ee_tick && !ee_clk_reg;
    assign ee_last = ee_tick && ee_clk_reg && (ee_bit_reg == 6'(EE_TOTAL - 1));

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ee_state_reg <= GSW_EE_IDLE;
            ee_bit_reg <= 6'h0;
            ee_div_reg <= 8'h00;
            ee_cmd_reg <= 8'h00;
            ee_shift_reg <= '0;
            ee_clk_reg <= 1'b0;
            ee_data_valid <= 1'b0;
            ee_data <= '0;
        end
        else
        begin
            ee_data_valid <= 1'b0;
            case (ee_state_reg)
                GSW_EE_IDLE:
                begin
                    ee_div_reg <= 8'h00;
                    ee_bit_reg <= 6'h0;
                    ee_clk_reg <= 1'b0;
                    if (ee_start && straps_valid)
                    begin
                        ee_cmd_reg <= ee_command;
                        ee_state_reg <= GSW_EE_SHIFT;
                    end
                end
                GSW_EE_SHIFT:
                begin
                    ee_div_reg <= ee_tick ? 8'h00 : ee_div_reg + 8'h01;
                    if (ee_tick)
                        ee_clk_reg <= !ee_clk_reg;
                    if (ee_rise && ee_bit_reg >= 6'h8)
                        ee_shift_reg <= {ee_shift_reg[EE_BITS-2:0], ee_in_sync};
                    if (ee_tick && ee_clk_reg)
                    begin
                        ee_bit_reg <= ee_bit_reg + 6'h1;
                        if (ee_bit_reg < 6'h8)
                            ee_cmd_reg <= {ee_cmd_reg[6:0], 1'b0};
                    end
                    if (ee_last)
                        ee_state_reg <= GSW_EE_DONE;
                end
                GSW_EE_DONE:
                begin
                    ee_data <= ee_shift_reg;
                    ee_data_valid <= 1'b1;
                    ee_state_reg <= GSW_EE_IDLE;
                end
                default: ee_state_reg <= GSW_EE_IDLE;
            endcase
        end
    end

    assign ee_busy = (ee_state_reg != GSW_EE_IDLE);
    assign eeprom_select = (ee_state_reg == GSW_EE_SHIFT);
    assign eeprom_clock_out = ee_clk_reg;
    assign eeprom_serial_out = ee_cmd_reg[7];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    org_capture_a: assert property (strap_take |=> eeprom_org_strap == $past(pin_sync[7]))
        else $error("organization strap not captured");
    rx_capture_a: assert property (strap_take |=> rx_termination_adjust == $past(pin_sync[6:5]))
        else $error("receive adjust not captured");
    tx_capture_a: assert property (strap_take |=> tx_termination_adjust == $past(pin_sync[4:3]))
        else $error("transmit adjust not captured");
    deq_capture_a: assert property (strap_take |=> driver_equalization == $past(pin_sync[2:0]))
        else $error("equalization not captured");
    strap_hold_a: assert property (straps_valid && $past(straps_valid) |-> $stable(driver_equalization))
        else $error("straps changed after capture");
    oe_init_a: assert property ($rose(straps_valid) |-> gpio_oe == GSW_OE_RESET)
        else $error("pin driven before straps taken");
    wake_follow_a: assert property (ring_sync && link_in_l2 |=> !wake_n)
        else $error("wake not asserted");
    wake_quiet_a: assert property (!link_in_l2 |=> wake_n)
        else $error("wake asserted outside L2");
    ee_select_a: assert property (ee_last |=> !eeprom_select ##1 ee_data_valid)
        else $error("EEPROM transfer end wrong");

    strap_cov_c: cover property (strap_take);
    wake_cov_c: cover property (!wake_n);
    ee_cov_c: cover property (ee_data_valid);
endmodule : gsw_top
